// [core/pin_mux_pkg.sv]
// Constants and carrier types for the port alternate function selector
//------------------------------------------------------------------------
// Summary of operation
// R1: Port1 bits 6,7 are ports only while timer ch1,ch2 outputs and gates are 0.
// R2: Port3 bit 1 is a port only while timer ch3 output and gate are 0.
// R3: Port4 bit 2 is a port only while timer ch4 output and gate are 0.
// R4: Port1 bit 5 is a port only while both calendar clock gates are 0.
// R5: Port3 bit 0 is a port only while the calendar one-hertz gate is 0.
// R6: Timer and calendar output gates reset to 0, pins start as ports.
// R7: With a debug tool connected, port4 bit 0 is the first debug line.
// R8: Single-line debug leaves port4 bit 1 an ordinary port.
// R9: Two-line debug makes port4 bit 1 the second debug line.
// R10: Software stops the two-wire unit before using port6 bits 0,1 as ports.
// R11: Port12 function select accepts one write after reset, later ones ignored.
// R12: Port12 pins given to an oscillator never act as inputs until reset.
// R13: Port1 bits 0..4 are ports only while their serial channels release them.
// R14: Port4 bits 3..5 are ports only while unit0 ch1 clocked serial is off.
// R15: Claimed pins follow the alternate function, released pins latch and dir.
//------------------------------------------------------------------------
package pin_mux_pkg;
  localparam int NPINS = 22;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Pin indices
  localparam int IX_PORT1_BIT0 = 0;
  localparam int IX_PORT1_BIT1 = 1;
  localparam int IX_PORT1_BIT2 = 2;
  localparam int IX_PORT1_BIT3 = 3;
  localparam int IX_PORT1_BIT4 = 4;
  localparam int IX_PORT1_BIT5 = 5;
  localparam int IX_PORT1_BIT6 = 6;
  localparam int IX_PORT1_BIT7 = 7;
  localparam int IX_PORT3_BIT0 = 8;
  localparam int IX_PORT3_BIT1 = 9;
  localparam int IX_PORT4_BIT0 = 10;
  localparam int IX_PORT4_BIT1 = 11;
  localparam int IX_PORT4_BIT2 = 12;
  localparam int IX_PORT4_BIT3 = 13;
  localparam int IX_PORT4_BIT4 = 14;
  localparam int IX_PORT4_BIT5 = 15;
  localparam int IX_PORT6_BIT0 = 16;
  localparam int IX_PORT6_BIT1 = 17;
  localparam int IX_PORT12_BIT1 = 18;
  localparam int IX_PORT12_BIT2 = 19;
  localparam int IX_PORT12_BIT3 = 20;
  localparam int IX_PORT12_BIT4 = 21;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PORT_LATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TIMER_OUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TIMER_GATE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAL_CTRL_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAL_CTRL_C = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OSC_SELECT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CLAIM = 8'h24;
  // Field positions
  localparam int CAL_A_CLK_GATE_BIT = 4;
  localparam int CAL_A_ONEHZ_BIT = 5;
  localparam int CAL_C_CLK_GATE_BIT = 6;
  localparam int OSC_MAIN_BIT = 0;
  localparam int OSC_SUB_BIT = 1;
  localparam int STAT_DEBUG_CONN_BIT = 0;
  localparam int STAT_DEBUG_TWO_BIT = 1;
  localparam int STAT_OSC_LOCK_BIT = 2;
  // Reset values
  localparam logic [NPINS-1:0] RST_PORT_LATCH = 22'h000000;
  localparam logic [NPINS-1:0] RST_PORT_DIR = 22'h000000;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_CAL_CTRL = 8'h00;
  localparam logic [1:0] RST_OSC_SELECT = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic base_clk;
    logic div_clk;
    logic second;
  } calendar_s;

  typedef struct packed {
    logic first_out;
    logic first_oe;
    logic second_out;
    logic second_oe;
  } debug_s;

  typedef struct packed {
    logic u0c0_claim;
    logic u0c0_clk_out;
    logic u0c0_data_out;
    logic u0c1_claim;
    logic u1c2_claim;
    logic u1c2_data_out;
    logic u1c3_claim;
    logic csi01_claim;
    logic csi01_clk_out;
    logic csi01_clk_oe;
    logic csi01_data_out;
  } serial_s;

  typedef struct packed {
    logic active;
    logic clk_drive_low;
    logic data_drive_low;
  } twowire_s;
endpackage

// [core/pin_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Asynchronous input and filtered level
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Stage one feeds only stage two
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule

// [core/pin_drive_cells.sv]
// Registered pin drivers choosing alternate function or port latch
`timescale 1ns/10ps
module pin_drive_cells #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Alternate function side
  input wire logic [WIDTH-1:0] alt_claim,
  input wire logic [WIDTH-1:0] alt_value,
  input wire logic [WIDTH-1:0] alt_oe,
  // Port side
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  // Pins
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);
  logic [WIDTH-1:0] next_pin_out;
  logic [WIDTH-1:0] next_pin_oe;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_pin_out[i] = alt_claim[i] ? alt_value[i] : latch[i]; // R15
      next_pin_oe[i] = alt_claim[i] ? alt_oe[i] : dir[i]; // R15
    end
  end

  // All pins, claimed or released, drop back to input at reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end
endmodule

// [core/port_alt_function_select.sv]
// Port pin sharing between general-purpose I/O and alternate functions
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module port_alt_function_select
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire bus_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  // Peripheral sources, same clock
  input wire calendar_s calendar,
  input wire debug_s debug,
  input wire serial_s serial,
  input wire twowire_s twowire,
  // Debug tool straps, from pins
  input wire logic debug_attach_pin,
  input wire logic debug_two_line_pin,
  // Pins
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  // Synchronised pin levels for peripherals
  output logic [NPINS-1:0] pin_level
);
  //----------------------------------------------------------------------
  // Register state
  //----------------------------------------------------------------------
  logic [NPINS-1:0] port_latch;
  logic [NPINS-1:0] port_dir;
  logic [7:0] timer_channel_output_reg;
  logic [7:0] timer_output_gate_reg;
  logic [7:0] calendar_ctrl_reg_a;
  logic [7:0] calendar_ctrl_reg_c;
  logic [1:0] osc_select;
  logic osc_locked;
  logic [NPINS-1:0] next_port_latch;
  logic [NPINS-1:0] next_port_dir;
  logic [7:0] next_timer_out;
  logic [7:0] next_timer_gate;
  logic [7:0] next_cal_a;
  logic [7:0] next_cal_c;
  logic [1:0] next_osc_select;
  logic next_osc_locked;
  logic [DATA_W-1:0] next_rdata;
  logic [NPINS-1:0] next_pin_level;

  logic [NPINS-1:0] sync_level;
  logic [1:0] dbg_sync;
  logic dbg_conn;
  logic dbg_two;
  logic [NPINS-1:0] alt_claim;
  logic [NPINS-1:0] alt_value;
  logic [NPINS-1:0] alt_oe;
  logic [NPINS-1:0] osc_mask;

  assign dbg_conn = dbg_sync[0];
  assign dbg_two = dbg_sync[1];

  function automatic logic hit(input bus_req_s req,
                               input logic [ADDR_W-1:0] ofs);
    hit = (req.addr == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [NPINS-1:0] v);
    widen = {{(DATA_W - NPINS){1'b0}}, v};
  endfunction

  //----------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------
  always_comb begin
    next_port_latch = port_latch;
    next_port_dir = port_dir;
    next_timer_out = timer_channel_output_reg;
    next_timer_gate = timer_output_gate_reg;
    next_cal_a = calendar_ctrl_reg_a;
    next_cal_c = calendar_ctrl_reg_c;
    next_osc_select = osc_select;
    next_osc_locked = osc_locked;
    if (bus_req.wr) begin
      if (hit(bus_req, OFS_PORT_LATCH)) begin
        next_port_latch = bus_req.wdata[NPINS-1:0];
      end
      if (hit(bus_req, OFS_PORT_DIR)) begin
        next_port_dir = bus_req.wdata[NPINS-1:0];
      end
      if (hit(bus_req, OFS_TIMER_OUT)) begin
        next_timer_out = bus_req.wdata[7:0];
      end
      if (hit(bus_req, OFS_TIMER_GATE)) begin
        next_timer_gate = bus_req.wdata[7:0];
      end
      if (hit(bus_req, OFS_CAL_CTRL_A)) begin
        next_cal_a = bus_req.wdata[7:0];
      end
      if (hit(bus_req, OFS_CAL_CTRL_C)) begin
        next_cal_c = bus_req.wdata[7:0];
      end
      // Only the first write after reset counts
      if (hit(bus_req, OFS_OSC_SELECT) && !osc_locked) begin // R11
        next_osc_select = bus_req.wdata[1:0];
        next_osc_locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port_latch <= RST_PORT_LATCH;
      port_dir <= RST_PORT_DIR;
      timer_channel_output_reg <= RST_TIMER; // R6
      timer_output_gate_reg <= RST_TIMER; // R6
      calendar_ctrl_reg_a <= RST_CAL_CTRL; // R6
      calendar_ctrl_reg_c <= RST_CAL_CTRL; // R6
      osc_select <= RST_OSC_SELECT;
      osc_locked <= 1'b0;
    end else begin
      port_latch <= next_port_latch;
      port_dir <= next_port_dir;
      timer_channel_output_reg <= next_timer_out;
      timer_output_gate_reg <= next_timer_gate;
      calendar_ctrl_reg_a <= next_cal_a;
      calendar_ctrl_reg_c <= next_cal_c;
      osc_select <= next_osc_select;
      osc_locked <= next_osc_locked;
    end
  end

  //----------------------------------------------------------------------
  // Alternate function claims
  //----------------------------------------------------------------------
  always_comb begin
    alt_claim = '0;
    alt_value = '0;
    alt_oe = '0;
    // Timer outputs; a stray output bit still claims the pin
    for (int ch = 1; ch <= 4; ch++) begin
      int ix;
      ix = (ch == 1) ? IX_PORT1_BIT6 : (ch == 2) ? IX_PORT1_BIT7 :
           (ch == 3) ? IX_PORT3_BIT1 : IX_PORT4_BIT2;
      alt_claim[ix] = timer_output_gate_reg[ch] |
                      timer_channel_output_reg[ch]; // R1 R2 R3
      alt_value[ix] = timer_channel_output_reg[ch];
      alt_oe[ix] = 1'b1;
    end
    // Calendar clock outputs
    alt_claim[IX_PORT1_BIT5] = calendar_ctrl_reg_a[CAL_A_CLK_GATE_BIT] |
                               calendar_ctrl_reg_c[CAL_C_CLK_GATE_BIT]; // R4
    alt_value[IX_PORT1_BIT5] = calendar_ctrl_reg_a[CAL_A_CLK_GATE_BIT] ?
                               calendar.base_clk : calendar.div_clk;
    alt_oe[IX_PORT1_BIT5] = 1'b1;
    alt_claim[IX_PORT3_BIT0] = calendar_ctrl_reg_a[CAL_A_ONEHZ_BIT]; // R5
    alt_value[IX_PORT3_BIT0] = calendar.second;
    alt_oe[IX_PORT3_BIT0] = 1'b1;
    // Debug lines
    alt_claim[IX_PORT4_BIT0] = dbg_conn; // R7
    alt_value[IX_PORT4_BIT0] = debug.first_out;
    alt_oe[IX_PORT4_BIT0] = debug.first_oe;
    alt_claim[IX_PORT4_BIT1] = dbg_conn & dbg_two; // R8 R9
    alt_value[IX_PORT4_BIT1] = debug.second_out;
    alt_oe[IX_PORT4_BIT1] = debug.second_oe;
    // Serial array channels on port 1
    alt_claim[IX_PORT1_BIT0] = serial.u0c0_claim; // R13
    alt_value[IX_PORT1_BIT0] = serial.u0c0_clk_out;
    alt_oe[IX_PORT1_BIT0] = 1'b1;
    alt_claim[IX_PORT1_BIT2] = serial.u0c0_claim; // R13
    alt_value[IX_PORT1_BIT2] = serial.u0c0_data_out;
    alt_oe[IX_PORT1_BIT2] = 1'b1;
    alt_claim[IX_PORT1_BIT1] = serial.u0c1_claim; // R13
    alt_claim[IX_PORT1_BIT3] = serial.u1c2_claim; // R13
    alt_value[IX_PORT1_BIT3] = serial.u1c2_data_out;
    alt_oe[IX_PORT1_BIT3] = 1'b1;
    alt_claim[IX_PORT1_BIT4] = serial.u1c3_claim; // R13
    // Clocked serial of unit0 ch1 on port 4
    alt_claim[IX_PORT4_BIT3] = serial.csi01_claim; // R14
    alt_value[IX_PORT4_BIT3] = serial.csi01_clk_out;
    alt_oe[IX_PORT4_BIT3] = serial.csi01_clk_oe;
    alt_claim[IX_PORT4_BIT4] = serial.csi01_claim; // R14
    alt_claim[IX_PORT4_BIT5] = serial.csi01_claim; // R14
    alt_value[IX_PORT4_BIT5] = serial.csi01_data_out;
    alt_oe[IX_PORT4_BIT5] = 1'b1;
    // Two-wire lines are open drain; software must stop the unit first
    alt_claim[IX_PORT6_BIT0] = twowire.active; // R10
    alt_oe[IX_PORT6_BIT0] = twowire.clk_drive_low;
    alt_claim[IX_PORT6_BIT1] = twowire.active; // R10
    alt_oe[IX_PORT6_BIT1] = twowire.data_drive_low;
    // Oscillator pins: never driven, never read as input
    for (int k = IX_PORT12_BIT1; k <= IX_PORT12_BIT4; k++) begin
      alt_claim[k] = osc_mask[k]; // R12
    end
  end

  always_comb begin
    osc_mask = '0;
    osc_mask[IX_PORT12_BIT1] = osc_select[OSC_MAIN_BIT];
    osc_mask[IX_PORT12_BIT2] = osc_select[OSC_MAIN_BIT];
    osc_mask[IX_PORT12_BIT3] = osc_select[OSC_SUB_BIT];
    osc_mask[IX_PORT12_BIT4] = osc_select[OSC_SUB_BIT];
  end

  pin_drive_cells #(
    .WIDTH(NPINS)
  ) u_cells (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .alt_claim(alt_claim),
    .alt_value(alt_value),
    .alt_oe(alt_oe),
    .latch(port_latch),
    .dir(port_dir),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  //----------------------------------------------------------------------
  // Input side
  //----------------------------------------------------------------------
  pin_sync3 #(
    .WIDTH(NPINS)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(pin_in),
    .level(sync_level)
  );

  pin_sync3 #(
    .WIDTH(2)
  ) u_dbg_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in({debug_two_line_pin, debug_attach_pin}),
    .level(dbg_sync)
  );

  always_comb begin
    next_pin_level = sync_level & ~osc_mask; // R12
    next_rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_PORT_LATCH: next_rdata = widen(port_latch);
        OFS_PORT_DIR: next_rdata = widen(port_dir);
        OFS_TIMER_OUT: next_rdata = {24'h000000, timer_channel_output_reg};
        OFS_TIMER_GATE: next_rdata = {24'h000000, timer_output_gate_reg};
        OFS_CAL_CTRL_A: next_rdata = {24'h000000, calendar_ctrl_reg_a};
        OFS_CAL_CTRL_C: next_rdata = {24'h000000, calendar_ctrl_reg_c};
        OFS_OSC_SELECT: next_rdata = {30'h0, osc_select};
        OFS_PIN_LEVEL: next_rdata = widen(pin_level);
        OFS_STATUS: next_rdata = {29'h0, osc_locked, dbg_two,
                                  dbg_conn};
        OFS_CLAIM: next_rdata = widen(alt_claim);
        default: next_rdata = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
      pin_level <= '0;
    end else begin
      rdata <= next_rdata;
      pin_level <= next_pin_level;
    end
  end

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_timer_port1;
    (!timer_output_gate_reg[1] && !timer_channel_output_reg[1])
      |=> (pin_oe[IX_PORT1_BIT6] == $past(port_dir[IX_PORT1_BIT6])) &&
          (pin_out[IX_PORT1_BIT6] == $past(port_latch[IX_PORT1_BIT6]));
  endproperty
  a_timer_port1: assert property (p_timer_port1) // R1
    else $error("port1 bit6 not under port control");

  property p_timer_port3;
    timer_output_gate_reg[3]
      |=> pin_oe[IX_PORT3_BIT1] &&
          (pin_out[IX_PORT3_BIT1] == $past(timer_channel_output_reg[3]));
  endproperty
  a_timer_port3: assert property (p_timer_port3) // R2
    else $error("port3 bit1 not driven by timer");

  property p_timer_port4;
    (!timer_output_gate_reg[4] && !timer_channel_output_reg[4])
      |=> pin_oe[IX_PORT4_BIT2] == $past(port_dir[IX_PORT4_BIT2]);
  endproperty
  a_timer_port4: assert property (p_timer_port4) // R3
    else $error("port4 bit2 not under port control");

  property p_cal_clk;
    (calendar_ctrl_reg_a[CAL_A_CLK_GATE_BIT] ||
     calendar_ctrl_reg_c[CAL_C_CLK_GATE_BIT]) |=> pin_oe[IX_PORT1_BIT5];
  endproperty
  a_cal_clk: assert property (p_cal_clk) // R4
    else $error("calendar clock pin not driven");

  property p_onehz;
    !calendar_ctrl_reg_a[CAL_A_ONEHZ_BIT]
      |=> pin_out[IX_PORT3_BIT0] == $past(port_latch[IX_PORT3_BIT0]);
  endproperty
  a_onehz: assert property (p_onehz) // R5
    else $error("port3 bit0 not following latch");

  property p_debug_first;
    dbg_conn |=> pin_oe[IX_PORT4_BIT0] == $past(debug.first_oe);
  endproperty
  a_debug_first: assert property (p_debug_first) // R7
    else $error("first debug line not on port4 bit0");

  property p_debug_single;
    (dbg_conn && !dbg_two)
      |=> pin_oe[IX_PORT4_BIT1] == $past(port_dir[IX_PORT4_BIT1]);
  endproperty
  a_debug_single: assert property (p_debug_single) // R8
    else $error("port4 bit1 taken in single-line mode");

  property p_debug_two;
    (dbg_conn && dbg_two)
      |=> pin_out[IX_PORT4_BIT1] == $past(debug.second_out);
  endproperty
  a_debug_two: assert property (p_debug_two) // R9
    else $error("second debug line not on port4 bit1");

  property p_osc_once;
    (osc_locked && bus_req.wr && bus_req.addr == OFS_OSC_SELECT)
      |=> $stable(osc_select);
  endproperty
  a_osc_once: assert property (p_osc_once) // R11
    else $error("oscillator select changed after first write");

  property p_osc_no_input;
    osc_select[OSC_MAIN_BIT] ##1 osc_select[OSC_MAIN_BIT]
      |-> !pin_level[IX_PORT12_BIT1] && !pin_oe[IX_PORT12_BIT2];
  endproperty
  a_osc_no_input: assert property (p_osc_no_input) // R12
    else $error("oscillator pin used as port");

  property p_serial_claim;
    serial.csi01_claim |=> !pin_oe[IX_PORT4_BIT4] && pin_oe[IX_PORT4_BIT5];
  endproperty
  a_serial_claim: assert property (p_serial_claim) // R14
    else $error("clocked serial pins not claimed");
endmodule

// [sim/board_model.sv]
// Board pulls and debug tool straps seen by the pin selector
`timescale 1ns/10ps
module board_model
  import pin_mux_pkg::*;
(
  // Device pins
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_in,
  // Board pull levels
  input wire logic [NPINS-1:0] pull,
  // Debug tool control
  input wire logic tool_on,
  input wire logic tool_two,
  output logic debug_attach_pin,
  output logic debug_two_line_pin
);
  //--------------------------------------------------------------
  // Pin levels
  //--------------------------------------------------------------
  // Released pins go to the pull level, never the last drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
  //--------------------------------------------------------------
  // Debug tool straps
  //--------------------------------------------------------------
  assign debug_attach_pin = tool_on;
  // Two-line mode only exists while the tool is attached
  assign debug_two_line_pin = tool_on & tool_two;
endmodule

// [sim/testbench.sv]
// Register and pin sequence tests for the port alternate selector
`timescale 1ns/10ps
module testbench;
  import pin_mux_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  bus_req_s bus_req = '0;
  calendar_s calendar = '0;
  debug_s debug = 4'h5;
  serial_s serial = '0;
  twowire_s twowire = '0;
  logic tool_on = 1'b0;
  logic tool_two = 1'b0;
  logic [NPINS-1:0] pull = '1;
  logic attach;
  logic two_line;
  logic [NPINS-1:0] pin_in;
  logic [NPINS-1:0] pin_out;
  logic [NPINS-1:0] pin_oe;
  logic [NPINS-1:0] pin_level;
  logic [DATA_W-1:0] rdata;
  int failures = 0;
  int checks = 0;
  logic [7:0] ta [7] = '{8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h10, 8'h14, 8'h10};
  logic [7:0] td [7] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h40, 8'h20};
  int tp [7] = '{6, 7, 9, 12, 5, 5, 8};

  always #5 clk_sys = ~clk_sys;

  port_alt_function_select u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
    .rdata(rdata), .calendar(calendar), .debug(debug),
    .serial(serial), .twowire(twowire),
    .debug_attach_pin(attach), .debug_two_line_pin(two_line),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level)
  );

  board_model u_board (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .pull(pull),
    .tool_on(tool_on), .tool_two(tool_two),
    .debug_attach_pin(attach), .debug_two_line_pin(two_line)
  );

  //--------------------------------------------------------------
  // Bus and check tasks
  //--------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // Data stands one cycle only, so both cycles are looked at
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk_sys);
    #1 chk("rdata_idle", 32'h0, rdata);
  endtask

  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //--------------------------------------------------------------
  // Watchdog
  //--------------------------------------------------------------
  initial begin
    tick(3000);
    failures++;
    report_and_stop;
  end

  //--------------------------------------------------------------
  // Test sequence
  //--------------------------------------------------------------
  initial begin
    tick(2);
    #1 chk("rst_oe", 32'h0, 32'(pin_oe));
    tick(1);
    resetn <= 1'b1;
    wr(8'h04, 32'h3fffff);
    wr(8'h00, 32'h3fffff);
    tick(2);
    #1 chk("idle_out", 32'h3fffff, 32'(pin_out));
    chk("idle_oe", 32'h3fffff, 32'(pin_oe));
    // Timer and calendar outputs, alternate value held at 0
    for (int i = 0; i < 7; i++) begin
      rd(ta[i], 32'h0);
      wr(ta[i], {24'h0, td[i]});
      tick(2);
      #1 chk("alt_out", 32'h0, 32'(pin_out[tp[i]]));
      chk("alt_oe", 32'h1, 32'(pin_oe[tp[i]]));
      rd(ta[i], {24'h0, td[i]});
      wr(ta[i], 32'h0);
      tick(2);
      #1 chk("port_out", 32'h1, 32'(pin_out[tp[i]]));
    end
    // Alternate values of 1 over a cleared latch; stray output bits claim
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h1e);
    wr(8'h10, 32'h30);
    @(posedge clk_sys);
    calendar <= 3'h5;
    tick(2);
    #1 chk("tmr_p1", 32'h3, 32'(pin_out[7:6]));
    chk("tmr_p3", 32'h1, 32'(pin_out[9]));
    chk("tmr_p4", 32'h1, 32'(pin_out[12]));
    chk("cal_val", 32'h3, 32'({pin_out[8], pin_out[5]}));
    rd(8'h08, 32'h1e);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h40);
    @(posedge clk_sys);
    calendar <= 3'h2;
    tick(2);
    #1 chk("cal_div", 32'h1, 32'(pin_out[5]));
    wr(8'h14, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h3fffff);
    // Serial channels claim, then release
    @(posedge clk_sys);
    serial <= 11'h4da;
    tick(2);
    #1 chk("ser_oe_lo", 32'hd, 32'(pin_oe[4:0]));
    chk("ser_out_lo", 32'h0, 32'(pin_out[3:2] | pin_out[0]));
    chk("ser_oe_hi", 32'h5, 32'(pin_oe[15:13]));
    chk("ser_out_hi", 32'h0, 32'(pin_out[15] | pin_out[13]));
    rd(8'h24, 32'h0000e01f);
    @(posedge clk_sys);
    serial <= '0;
    tick(2);
    #1 chk("ser_rel", 32'hff, 32'({pin_out[15:13], pin_out[4:0]}));
    // Two-wire open drain, stopped before port use
    @(posedge clk_sys);
    twowire <= 3'h6;
    tick(2);
    #1 chk("iic_oe", 32'h1, 32'(pin_oe[17:16]));
    chk("iic_out", 32'h0, 32'(pin_out[16]));
    @(posedge clk_sys);
    twowire <= '0;
    tick(2);
    #1 chk("iic_port", 32'h3, 32'(pin_out[17:16]));
    // Debug tool, single-line then two-line
    @(posedge clk_sys);
    tool_on <= 1'b1;
    tick(8);
    #1 chk("dbg_one", 32'h2, 32'(pin_out[11:10]));
    rd(8'h20, 32'h1);
    @(posedge clk_sys);
    tool_two <= 1'b1;
    tick(8);
    #1 chk("dbg_two", 32'h0, 32'(pin_out[11:10]));
    rd(8'h20, 32'h3);
    @(posedge clk_sys);
    tool_on <= 1'b0;
    tool_two <= 1'b0;
    tick(8);
    #1 chk("dbg_off", 32'h3, 32'(pin_out[11:10]));
    // Oscillator select, write once
    wr(8'h18, 32'h1);
    tick(6);
    #1 chk("osc_oe", 32'hc, 32'(pin_oe[21:18]));
    chk("osc_level", 32'hc, 32'(pin_level[21:18]));
    rd(8'h1c, 32'h0033ffff);
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h2);
    rd(8'h18, 32'h1);
    rd(8'h20, 32'h4);
    wr(8'h20, 32'hff);
    rd(8'h20, 32'h4);
    rd(8'h30, 32'h0);
    // Second reset clears the lock
    @(posedge clk_sys);
    resetn <= 1'b0;
    tick(1);
    #1 chk("rst2_oe", 32'h0, 32'(pin_oe));
    tick(2);
    resetn <= 1'b1;
    rd(8'h18, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h18, 32'h2);
    rd(8'h18, 32'h2);
    rd(8'h24, 32'h00300000);
    report_and_stop;
  end
endmodule
